// >>> hw/vcip_top.sv
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "vcip_regs.svh"

// What this block does
// - split flag pulse reaches shift clock during blanking
// - shift clock is loop clock, gated during blanking
// - system blank used outside legacy mode two, delayed
// - reset selects legacy mode two
// - selected syncs delayed, each invertible by control bits
// - legacy mode two takes blank from legacy input
// - aux clock divided from dot clock, programmable
// - legacy 8-bit port selectable as pixel input
// - host write captured at write strobe rising edge
// - host read data driven while read strobe low
// - width pin high selects 8-bit palette data
// - 6-bit mode shifts converter data up, zero-fills
// - 6-bit palette readback zeroes two top bits
// - software can override the width pin
// - override bit two, width from bit three
module vcip_top (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// register bus, write
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// register bus, read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// video control pins
	input  wire logic        system_blank_n,
	input  wire logic        system_hsync_in,
	input  wire logic        system_vsync_in,
	input  wire logic        legacy_blank_n,
	input  wire logic        legacy_hsync_in,
	input  wire logic        legacy_vsync_in,
	input  wire logic        split_transfer_flag,
	input  wire logic [7:0]  legacy_pixel_port,
	input  wire logic [7:0]  system_pixel_in,
	input  wire logic        width_select,
	// host strobe port
	input  wire logic        host_wr_n,
	input  wire logic        host_rd_n,
	input  wire logic [3:0]  host_reg_select,
	input  wire logic [7:0]  host_data_in,
	output logic [7:0]       host_data_out,
	output logic             host_data_oe,
	// video outputs
	output logic [7:0]       dac_data,
	output logic             dac_blank_n,
	output logic             hsync_output,
	output logic             vsync_output,
	output logic             shift_clock,
	output logic             loop_clock_out,
	output logic             aux_divided_clock
);

	////////////////////////////////////////////////////////////////////////
	// helpers

	// byte-lane merge of a bus write
	function automatic logic [31:0] vcip_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
				res[b*8 +: 8] = new_v[b*8 +: 8];
		end
		return res;
	endfunction

	// divider terminal count
	function automatic logic vcip_div_end(input logic [7:0] cnt,
		input logic [7:0] ratio);
		return cnt >= ratio;
	endfunction

	// palette byte as seen in 6-bit mode on readback
	function automatic logic [7:0] vcip_pal_read(input logic [7:0] v,
		input logic wide);
		return wide ? v : {2'h0, v[5:0]};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers, every pin passes two flops

	localparam int PW = 38;
	logic [PW-1:0] pin_meta;
	logic [PW-1:0] pin_sync;
	logic [PW-1:0] next_pin_meta;
	logic [PW-1:0] next_pin_sync;

	always_comb
	begin
		next_pin_meta = {system_blank_n, system_hsync_in, system_vsync_in,
			legacy_blank_n, legacy_hsync_in, legacy_vsync_in,
			split_transfer_flag, width_select, host_wr_n, host_rd_n,
			host_reg_select, host_data_in, legacy_pixel_port,
			system_pixel_in};
		next_pin_sync = pin_meta;
	end

	// strobes idle high after reset so no false edge is seen
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_meta <= 38'h0030000000; // write and read strobes high
			pin_sync <= 38'h0030000000;
		end
		else
		begin
			pin_meta <= next_pin_meta;
			pin_sync <= next_pin_sync;
		end
	end

	logic       s_sys_bl_n, s_sys_hs, s_sys_vs, s_leg_bl_n, s_leg_hs;
	logic       s_leg_vs, s_split, s_width, s_wr_n, s_rd_n;
	logic [3:0] s_rs;
	logic [7:0] s_hdata, s_leg_pix, s_sys_pix;
	assign {s_sys_bl_n, s_sys_hs, s_sys_vs, s_leg_bl_n, s_leg_hs, s_leg_vs,
		s_split, s_width, s_wr_n, s_rd_n, s_rs, s_hdata, s_leg_pix,
		s_sys_pix} = pin_sync;

	////////////////////////////////////////////////////////////////////////
	// control registers, bus slave and host strobe port

	logic [7:0]  gen_ctrl, misc_ctrl, mode_ctrl, pal_data, host_index;
	logic [15:0] clk_div;
	logic [7:0]  next_gen_ctrl, next_misc_ctrl, next_mode_ctrl;
	logic [7:0]  next_pal_data, next_host_index;
	logic [15:0] next_clk_div;
	logic        aw_held, w_held, next_aw_held, next_w_held;
	logic [7:0]  awaddr_q, next_awaddr_q;
	logic [31:0] wdata_q, next_wdata_q;
	logic [3:0]  wstrb_q, next_wstrb_q;
	logic        bvalid, next_bvalid, rvalid, next_rvalid;
	logic [1:0]  bresp, next_bresp, rresp, next_rresp;
	logic [31:0] rdata, next_rdata;
	logic        wr_n_prev, next_wr_n_prev;
	logic [7:0]  hrdata, next_hrdata;
	logic        wide, blank_active;

	// override bit wins over the pin; pin low means 6-bit
	assign wide = misc_ctrl[`VCIP_MISC_OVERRIDE] ?
		misc_ctrl[`VCIP_MISC_SOFT_8BIT] : s_width;

	assign s_axi_awready = !aw_held && !bvalid;
	assign s_axi_wready  = !w_held && !bvalid;
	assign s_axi_arready = !rvalid;

	// bus read mux; unmapped offsets answer with an error and zero
	function automatic logic [32:0] vcip_bus_read(input logic [7:0] a);
		case (a)
			`VCIP_GEN_CTRL_OFS:  return {1'b0, 24'h0, gen_ctrl};
			`VCIP_MISC_CTRL_OFS: return {1'b0, 24'h0, misc_ctrl};
			`VCIP_MODE_CTRL_OFS: return {1'b0, 24'h0, mode_ctrl};
			`VCIP_CLK_DIV_OFS:   return {1'b0, 16'h0, clk_div};
			`VCIP_PAL_DATA_OFS:
				return {1'b0, 24'h0, vcip_pal_read(pal_data, wide)};
			`VCIP_STATUS_OFS:    return {1'b0, 28'h0,
				misc_ctrl[`VCIP_MISC_OVERRIDE],
				mode_ctrl[`VCIP_MODE_LEGACY2], blank_active, wide};
			default:             return {1'b1, 32'h0};
		endcase
	endfunction

	always_comb
	begin
		logic        bus_wr;
		logic        host_wr;
		logic [32:0] rd;
		logic [31:0] m;
		bus_wr = 1'b0;
		host_wr = 1'b0;
		rd = 33'h0;
		m = 32'h0;
		next_gen_ctrl = gen_ctrl;
		next_misc_ctrl = misc_ctrl;
		next_mode_ctrl = mode_ctrl;
		next_clk_div = clk_div;
		next_pal_data = pal_data;
		next_host_index = host_index;
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_awaddr_q = awaddr_q;
		next_wdata_q = wdata_q;
		next_wstrb_q = wstrb_q;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rresp = rresp;
		next_rdata = rdata;
		next_wr_n_prev = s_wr_n;
		// address and data are taken in either order and held
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_aw_held = 1'b1;
			next_awaddr_q = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_w_held = 1'b1;
			next_wdata_q = s_axi_wdata;
			next_wstrb_q = s_axi_wstrb;
		end
		if (bvalid && s_axi_bready)
			next_bvalid = 1'b0;
		// write lands one cycle after both halves are held
		if (aw_held && w_held && !bvalid)
		begin
			bus_wr = 1'b1;
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = `VCIP_RESP_OKAY;
			case (awaddr_q)
				`VCIP_GEN_CTRL_OFS:
				begin
					m = vcip_merge({24'h0, gen_ctrl}, wdata_q, wstrb_q);
					next_gen_ctrl = m[7:0];
				end
				`VCIP_MISC_CTRL_OFS:
				begin
					m = vcip_merge({24'h0, misc_ctrl}, wdata_q, wstrb_q);
					next_misc_ctrl = m[7:0];
				end
				`VCIP_MODE_CTRL_OFS:
				begin
					m = vcip_merge({24'h0, mode_ctrl}, wdata_q, wstrb_q);
					next_mode_ctrl = m[7:0];
				end
				`VCIP_CLK_DIV_OFS:
				begin
					m = vcip_merge({16'h0, clk_div}, wdata_q, wstrb_q);
					next_clk_div = m[15:0];
				end
				`VCIP_PAL_DATA_OFS:
				begin
					m = vcip_merge({24'h0, pal_data}, wdata_q, wstrb_q);
					next_pal_data = m[7:0]; // full byte kept
				end
				`VCIP_STATUS_OFS: next_bresp = `VCIP_RESP_OKAY;
				default:          next_bresp = `VCIP_RESP_SLVERR;
			endcase
		end
		if (rvalid && s_axi_rready)
			next_rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			rd = vcip_bus_read(s_axi_araddr);
			next_rvalid = 1'b1;
			next_rdata = rd[31:0];
			next_rresp = rd[32] ? `VCIP_RESP_SLVERR : `VCIP_RESP_OKAY;
		end
		// host write lands on the strobe's rising edge, unless the bus writes in that cycle
		host_wr = !wr_n_prev && s_wr_n;
		if (host_wr && !bus_wr)
		begin
			case (s_rs)
				`VCIP_RS_INDEX:    next_host_index = s_hdata;
				`VCIP_RS_PAL_DATA: next_pal_data = s_hdata;
				`VCIP_RS_INDEXED:
				begin
					if (host_index == `VCIP_IDX_GEN_CTRL)
						next_gen_ctrl = s_hdata;
					else if (host_index == `VCIP_IDX_MISC_CTRL)
						next_misc_ctrl = s_hdata;
				end
				default: next_host_index = host_index;
			endcase
		end
		// host read data follows the selected register
		case (s_rs)
			`VCIP_RS_INDEX:    next_hrdata = host_index;
			`VCIP_RS_PAL_DATA: next_hrdata = vcip_pal_read(pal_data, wide);
			`VCIP_RS_INDEXED:
				next_hrdata = (host_index == `VCIP_IDX_GEN_CTRL) ? gen_ctrl :
					(host_index == `VCIP_IDX_MISC_CTRL) ? misc_ctrl : 8'h00;
			default:           next_hrdata = 8'h00;
		endcase
	end

	// a host write in the same cycle as a bus write is dropped
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			gen_ctrl <= `VCIP_GEN_CTRL_RST;
			misc_ctrl <= `VCIP_MISC_CTRL_RST; // pin governs
			mode_ctrl <= `VCIP_MODE_CTRL_RST; // legacy mode two
			clk_div <= `VCIP_CLK_DIV_RST;
			pal_data <= `VCIP_PAL_DATA_RST;
			host_index <= 8'h00;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			bvalid <= 1'b0;
			bresp <= `VCIP_RESP_OKAY;
			rvalid <= 1'b0;
			rresp <= `VCIP_RESP_OKAY;
			rdata <= 32'h0;
			wr_n_prev <= 1'b1;
			hrdata <= 8'h00;
		end
		else
		begin
			gen_ctrl <= next_gen_ctrl;
			misc_ctrl <= next_misc_ctrl;
			mode_ctrl <= next_mode_ctrl;
			clk_div <= next_clk_div;
			pal_data <= next_pal_data;
			host_index <= next_host_index;
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			awaddr_q <= next_awaddr_q;
			wdata_q <= next_wdata_q;
			wstrb_q <= next_wstrb_q;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rresp <= next_rresp;
			rdata <= next_rdata;
			wr_n_prev <= next_wr_n_prev;
			hrdata <= next_hrdata;
		end
	end

	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rresp = rresp;
	assign s_axi_rdata = rdata;
	assign host_data_out = hrdata;
	assign host_data_oe = !s_rd_n;

	////////////////////////////////////////////////////////////////////////
	// video path: source select, common delay, output formatting

	logic                      legacy2;
	vcip_pkg::vcip_pipe_word_t pipe_in;
	vcip_pkg::vcip_pipe_word_t pipe_out;

	assign legacy2 = mode_ctrl[`VCIP_MODE_LEGACY2];

	// one delay line for all fields keeps them aligned
	always_comb
	begin
		pipe_in[7:0] = mode_ctrl[`VCIP_MODE_PORT_SEL] ?
			s_leg_pix : s_sys_pix;
		pipe_in[8] = legacy2 ? s_leg_bl_n : s_sys_bl_n;
		pipe_in[9] = legacy2 ? s_leg_hs : s_sys_hs;
		pipe_in[10] = legacy2 ? s_leg_vs : s_sys_vs;
	end

	vcip_delay #(
		.WIDTH (11),
		.DEPTH (`VCIP_PIPE_DEPTH)
	) u_delay (
		.aclk    (aclk),
		.aresetn (aresetn),
		.din     (pipe_in),
		.dout    (pipe_out)
	);

	assign blank_active = !pipe_out[8];

	////////////////////////////////////////////////////////////////////////
	// clock dividers and registered video outputs

	logic [7:0] loop_cnt, aux_cnt, next_loop_cnt, next_aux_cnt;
	logic       loop_lvl, aux_lvl, next_loop_lvl, next_aux_lvl;
	logic [7:0] next_dac_data;
	logic       next_dac_blank_n, next_hs, next_vs, next_sclk;

	always_comb
	begin
		next_loop_cnt = loop_cnt + 8'h01;
		next_loop_lvl = loop_lvl;
		if (vcip_div_end(loop_cnt, clk_div[15:8]))
		begin
			next_loop_cnt = 8'h00;
			next_loop_lvl = !loop_lvl;
		end
		// aux clock comes straight from the dot clock
		next_aux_cnt = aux_cnt + 8'h01;
		next_aux_lvl = aux_lvl;
		if (vcip_div_end(aux_cnt, clk_div[7:0]))
		begin
			next_aux_cnt = 8'h00;
			next_aux_lvl = !aux_lvl;
		end
		next_dac_data = wide ? pipe_out[7:0] :
			{pipe_out[5:0], 2'h0};
		next_dac_blank_n = pipe_out[8];
		next_hs = pipe_out[9] ^ gen_ctrl[`VCIP_GEN_HS_INV];
		next_vs = pipe_out[10] ^ gen_ctrl[`VCIP_GEN_VS_INV];
		// gated off in blanking except for a split-transfer pulse
		next_sclk = blank_active ? s_split : next_loop_lvl;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			loop_cnt <= 8'h00;
			aux_cnt <= 8'h00;
			loop_lvl <= 1'b0;
			aux_lvl <= 1'b0;
			dac_data <= 8'h00;
			dac_blank_n <= 1'b0;
			hsync_output <= 1'b0;
			vsync_output <= 1'b0;
			shift_clock <= 1'b0;
		end
		else
		begin
			loop_cnt <= next_loop_cnt;
			aux_cnt <= next_aux_cnt;
			loop_lvl <= next_loop_lvl;
			aux_lvl <= next_aux_lvl;
			dac_data <= next_dac_data;
			dac_blank_n <= next_dac_blank_n;
			hsync_output <= next_hs;
			vsync_output <= next_vs;
			shift_clock <= next_sclk;
		end
	end

	assign loop_clock_out = loop_lvl;
	assign aux_divided_clock = aux_lvl;

endmodule // vcip_top

// >>> hw/vcip_regs.svh
`ifndef VCIP_REGS_SVH
`define VCIP_REGS_SVH

// register byte offsets on the bus
`define VCIP_GEN_CTRL_OFS   8'h00
`define VCIP_MISC_CTRL_OFS  8'h04
`define VCIP_MODE_CTRL_OFS  8'h08
`define VCIP_CLK_DIV_OFS    8'h0C
`define VCIP_PAL_DATA_OFS   8'h10
`define VCIP_STATUS_OFS     8'h14

// reset values
`define VCIP_GEN_CTRL_RST   8'h00
`define VCIP_MISC_CTRL_RST  8'h00
`define VCIP_MODE_CTRL_RST  8'h03
`define VCIP_CLK_DIV_RST    16'h0001
`define VCIP_PAL_DATA_RST   8'h00

// field positions
`define VCIP_GEN_HS_INV     0
`define VCIP_GEN_VS_INV     1
`define VCIP_MISC_OVERRIDE  2
`define VCIP_MISC_SOFT_8BIT 3
`define VCIP_MODE_LEGACY2   0
`define VCIP_MODE_PORT_SEL  1

// host strobe port select codes and indirect indices
`define VCIP_RS_INDEX       4'h0
`define VCIP_RS_PAL_DATA    4'h1
`define VCIP_RS_INDEXED     4'hA
`define VCIP_IDX_GEN_CTRL   8'h1D
`define VCIP_IDX_MISC_CTRL  8'h1E

// pipeline depth shared by pixels, blank and syncs
`define VCIP_PIPE_DEPTH     3

// bus responses
`define VCIP_RESP_OKAY      2'h0
`define VCIP_RESP_SLVERR    2'h2

`endif

// >>> hw/vcip_pkg.sv
package vcip_pkg;

	// one byte of register or pixel data
	typedef logic [7:0] vcip_byte_t;

	// word carried down the video pipeline
	typedef logic [10:0] vcip_pipe_word_t;

endpackage

// >>> hw/vcip_delay.sv
`timescale 1ns/1ps

// fixed delay line, one register per stage
module vcip_delay #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 3
) (
	// clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// data
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] stage      [DEPTH];
	logic [WIDTH-1:0] next_stage [DEPTH];

	// shift one stage per clock
	always_comb
	begin
		next_stage[0] = din;
		for (int i = 1; i < DEPTH; i++)
		begin
			next_stage[i] = stage[i-1];
		end
	end

	// zero at reset so blank_n reads as blanking until real data arrives
	always_ff @(posedge aclk)
	begin
		for (int i = 0; i < DEPTH; i++)
		begin
			if (!aresetn)
				stage[i] <= '0;
			else
				stage[i] <= next_stage[i];
		end
	end

	assign dout = stage[DEPTH-1];

endmodule // vcip_delay

// >>> test/vcip_gfx_model.sv
`timescale 1ns/1ps

// graphics controller stand-in: a fixed 40-cycle raster, timed by aclk
module vcip_gfx_model (
	// clock
	input  wire logic aclk,
	// video control pins
	output logic       system_blank_n,
	output logic       system_hsync_in,
	output logic       system_vsync_in,
	output logic       legacy_blank_n,
	output logic       legacy_hsync_in,
	output logic       legacy_vsync_in,
	output logic       split_transfer_flag,
	// pixel pins
	output logic [7:0] legacy_pixel_port,
	output logic [7:0] system_pixel_in
);
	logic [5:0] col = 6'h00;
	logic [3:0] line = 4'h0;

	// raster position; never timed by the aux clock
	always_ff @(posedge aclk)
	begin
		col <= (col == 6'h27) ? 6'h00 : col + 6'h01;
		if (col == 6'h27)
			line <= line + 4'h1;
	end

	// the two blank sets overlap only partly and the two sync sets not at all, so selection shows
	assign legacy_blank_n = col < 6'h18;
	assign system_blank_n = !(col >= 6'h14 && col < 6'h24);
	// both sync sets active low, as green sync needs
	assign legacy_hsync_in = !(col >= 6'h1C && col < 6'h20);
	assign system_hsync_in = !(col >= 6'h16 && col < 6'h1A);
	assign legacy_vsync_in = line[1:0] != 2'h0;
	assign system_vsync_in = line[1:0] != 2'h1;
	// split pulse on odd lines, inside the overlap of both blanks
	assign split_transfer_flag = line[0] && col >= 6'h1A && col < 6'h23;
	assign legacy_pixel_port = {line[1:0], col};
	assign system_pixel_in = ~{col, line[1:0]};
endmodule // vcip_gfx_model

// >>> test/vcip_properties.sv
`timescale 1ns/1ps

// port-level checker for the video control block
module vcip_checker (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// register bus
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	// video and host strobe
	input wire logic        system_blank_n,
	input wire logic        legacy_blank_n,
	input wire logic        split_transfer_flag,
	input wire logic        host_rd_n,
	input wire logic        host_data_oe,
	input wire logic        dac_blank_n,
	input wire logic        shift_clock
);
	logic [3:0] up, next_up, hi, next_hi, lo, next_lo;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// age since reset and flag run lengths; saturate so they never wrap
	always_comb
	begin
		next_up = (up == 4'hF) ? up : up + 4'h1;
		next_hi = !split_transfer_flag ? 4'h0 : (hi == 4'hF) ? hi : hi + 4'h1;
		next_lo = split_transfer_flag ? 4'h0 : (lo == 4'hF) ? lo : lo + 4'h1;
	end

	always_ff @(posedge aclk)
	begin
		up <= aresetn ? next_up : 4'h0;
		hi <= aresetn ? next_hi : 4'h0;
		lo <= aresetn ? next_lo : 4'h0;
	end

	////////////////////////////////////////////////////////////////////////
	chk_blank_follow: assert property (up >= 4'h8 &&
		$past(system_blank_n, 6) == $past(legacy_blank_n, 6)
		|-> dac_blank_n == $past(legacy_blank_n, 6))
		else $error("blank output not six cycles behind pins");
	chk_shift_split: assert property (hi >= 4'h8 && !dac_blank_n
		&& !$past(dac_blank_n) |-> shift_clock)
		else $error("split pulse missing on shift clock");
	chk_shift_gated: assert property (lo >= 4'h8 && !dac_blank_n
		&& !$past(dac_blank_n) |-> !shift_clock)
		else $error("shift clock not gated in blanking");
	chk_oe_on: assert property ((!host_rd_n && up >= 4'h3) [*3]
		|-> host_data_oe)
		else $error("read data not driven while strobe low");
	chk_oe_off: assert property ((host_rd_n && up >= 4'h3) [*3]
		|-> !host_data_oe)
		else $error("read data driven with strobe high");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid)
		else $error("read answer late");
	chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");
	chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while answer pending");

	cover property (hi >= 4'h8 && !dac_blank_n);
	cover property (s_axi_rvalid && !s_axi_rready);
	cover property (!host_rd_n [*3]);
endmodule // vcip_checker

bind vcip_top vcip_checker u_chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.system_blank_n(system_blank_n), .legacy_blank_n(legacy_blank_n),
	.split_transfer_flag(split_transfer_flag), .host_rd_n(host_rd_n),
	.host_data_oe(host_data_oe), .dac_blank_n(dac_blank_n),
	.shift_clock(shift_clock));

// >>> test/tb.sv
`timescale 1ns/1ps
`include "vcip_regs.svh"

// self-checking bench for the video control block
module tb;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, host_data_in, host_data_out;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb, host_reg_select;
	logic [1:0]  s_axi_bresp, s_axi_rresp, em, eg;
	logic        system_blank_n, system_hsync_in, system_vsync_in;
	logic        legacy_blank_n, legacy_hsync_in, legacy_vsync_in;
	logic        split_transfer_flag, width_select, host_wr_n, host_rd_n;
	logic [7:0]  legacy_pixel_port, system_pixel_in, dac_data, px;
	logic        host_data_oe, dac_blank_n, hsync_output, vsync_output;
	logic        shift_clock, loop_clock_out, aux_divided_clock, ew, vid_chk;
	logic [5:0][21:0] hist;
	logic [21:0] pv;
	int          fail_count, n_compared, cyc;

	vcip_top dut (.*);
	vcip_gfx_model u_gfx (.*);

	initial
	begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// 6-bit mode moves the word up and zero-fills the two low bits
	function automatic logic [7:0] fmt(input logic [7:0] p, input logic w8);
		return w8 ? p : {p[5:0], 2'b00};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// a hang counts as a mismatch
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			fail_count++;
			final_report();
		end
	end

	// outputs trail the pins by six cycles; hist[5] is six samples old
	always @(posedge aclk)
	begin
		pv = hist[5];
		hist <= {hist[4:0], system_blank_n, system_hsync_in, system_vsync_in,
			legacy_blank_n, legacy_hsync_in, legacy_vsync_in,
			legacy_pixel_port, system_pixel_in};
		px = em[1] ? pv[15:8] : pv[7:0];
		if (vid_chk)
		begin
			chk(dac_blank_n, em[0] ? pv[18] : pv[21]);
			chk(hsync_output, (em[0] ? pv[17] : pv[20]) ^ eg[0]);
			chk(vsync_output, (em[0] ? pv[16] : pv[19]) ^ eg[1]);
			if (dac_blank_n === 1'b1)
			begin
				chk(dac_data, fmt(px, ew));
				chk(shift_clock, loop_clock_out);
			end
		end
	end

	// bus write; entered just after an edge, bready late by 0 to 2 cycles
	task automatic axw(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic aw, w;
		begin
			aw = 1'b1;
			w = 1'b1;
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			while (aw || w)
			begin
				@(posedge aclk);
				if (aw && s_axi_awready)
				begin
					aw = 1'b0;
					s_axi_awvalid <= 1'b0;
				end
				if (w && s_axi_wready)
				begin
					w = 1'b0;
					s_axi_wvalid <= 1'b0;
				end
			end
			repeat ($urandom % 3) @(posedge aclk);
			s_axi_bready <= 1'b1;
			do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
			r = s_axi_bresp;
			s_axi_bready <= 1'b0;
		end
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		repeat ($urandom % 3) @(posedge aclk);
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// host strobe write; strobe low and high for longer than three cycles
	task automatic hwr(input logic [3:0] s, input logic [7:0] v);
		host_reg_select <= s;
		host_data_in <= v;
		host_wr_n <= 1'b0;
		repeat (4) @(posedge aclk);
		host_wr_n <= 1'b1;
		repeat (6) @(posedge aclk);
	endtask

	// set mode, polarity and width, then watch the video for 120 cycles
	task automatic cfg(input logic [1:0] m, input logic [1:0] g,
		input logic [3:0] mc, input logic wp);
		logic [31:0] d;
		logic [1:0]  r;
		begin
			width_select <= wp;
			axw(`VCIP_MODE_CTRL_OFS, {30'h0, m}, r);
			axw(`VCIP_GEN_CTRL_OFS, {30'h0, g}, r);
			axw(`VCIP_MISC_CTRL_OFS, {28'h0, mc}, r);
			em = m;
			eg = g;
			ew = mc[2] ? mc[3] : wp;
			repeat (10) @(posedge aclk);
			vid_chk <= 1'b1;
			repeat (120) @(posedge aclk);
			vid_chk <= 1'b0;
			axr(`VCIP_STATUS_OFS, d, r);
			chk(d[0], ew);
		end
	endtask

	// aux (sel 0) or loop (sel 1) clock: cycles between two toggles
	task automatic per(input logic sel, output int n);
		logic v;
		for (int k = 0; k < 2; k++)
		begin
			v = sel ? loop_clock_out : aux_divided_clock;
			n = 0;
			do
			begin
				@(posedge aclk);
				n++;
			end
			while ((sel ? loop_clock_out : aux_divided_clock) === v);
		end
	endtask

	initial
	begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [7:0]  b;
		int          n;
		void'($urandom(35));
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, vid_chk} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		{host_reg_select, host_data_in, host_wr_n, host_rd_n} = 14'h3;
		s_axi_wstrb = 4'hF;
		width_select = 1'b0;
		{em, eg, ew} = 5'h18;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axr(`VCIP_MODE_CTRL_OFS, d, r);
		chk(d, `VCIP_MODE_CTRL_RST);
		axr(`VCIP_MISC_CTRL_OFS, d, r);
		chk(d, `VCIP_MISC_CTRL_RST);
		axr(`VCIP_STATUS_OFS, d, r);
		chk({d[2], d[0]}, 2'b10);
		axr(8'h18, d, r);
		chk(d, 32'h0);
		chk(r, `VCIP_RESP_SLVERR);
		axw(8'h18, 32'hFF, r);
		chk(r, `VCIP_RESP_SLVERR);
		for (int i = 0; i < 8; i++)
		begin
			b = (i < 4) ? 8'(i * 21) : 8'($urandom);
			cfg(b[1:0], b[3:2], {b[5:4], 2'b00}, b[6]);
		end
		b = 8'($urandom) | 8'hC0;
		axw(`VCIP_PAL_DATA_OFS, {24'h0, b}, r);
		axw(`VCIP_MISC_CTRL_OFS, 32'h4, r);
		axr(`VCIP_PAL_DATA_OFS, d, r);
		chk(d, {26'h0, b[5:0]});
		axw(`VCIP_MISC_CTRL_OFS, 32'hC, r);
		axr(`VCIP_PAL_DATA_OFS, d, r);
		chk(d, {24'h0, b});
		hwr(`VCIP_RS_INDEX, `VCIP_IDX_GEN_CTRL);
		b = 8'($urandom) & 8'h03;
		hwr(`VCIP_RS_INDEXED, b);
		axr(`VCIP_GEN_CTRL_OFS, d, r);
		chk(d, {24'h0, b});
		host_rd_n <= 1'b0;
		repeat (4) @(posedge aclk);
		chk({host_data_oe, host_data_out}, {1'b1, b});
		host_rd_n <= 1'b1;
		repeat (4) @(posedge aclk);
		chk(host_data_oe, 1'b0);
		b = 8'($urandom_range(5, 1));
		axw(`VCIP_CLK_DIV_OFS, {16'h0, b, b}, r);
		per(1'b0, n);
		chk(n, b + 8'h1);
		per(1'b1, n);
		chk(n, b + 8'h1);
		final_report();
	end
endmodule // tb
